/* rtl/brs_pkg.sv */
// Package for the bus remote state and error flag block: register map, fields, types.
package brs_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [11:0] BRS_ADDR_STATUS = 12'h000;
	localparam logic [11:0] BRS_ADDR_ERRWORD = 12'h004;
	localparam logic [11:0] BRS_ADDR_CTRL = 12'h008;
	localparam logic [11:0] BRS_ADDR_ADDR = 12'h00C;

	// ==========================================
	// Error status word bit positions
	localparam int BRS_E_CMD = 0;
	localparam int BRS_E_OPT = 1;
	localparam int BRS_E_LOOP = 2;
	localparam int BRS_E_NREM = 3;
	localparam int BRS_E_NSET = 4;
	localparam int BRS_E_OVR = 5;
	localparam int BRS_E_SETUP = 6;
	localparam int BRS_E_RAM = 7;
	localparam int BRS_E_ROM = 8;
	localparam int BRS_E_CARD = 9;
	localparam int BRS_NERR = 10;

	// Status register bit positions.
	localparam int BRS_S_TALK = 0;
	localparam int BRS_S_LISTEN = 1;
	localparam int BRS_S_REMOTE = 2;
	localparam int BRS_S_LOCKOUT = 3;
	localparam int BRS_S_DISCARD = 4;
	localparam int BRS_S_BUSY = 5;
	localparam int BRS_S_SETTLE = 6;
	localparam int BRS_S_MSG = 7;

	// Control register bit positions.
	localparam int BRS_C_SRQEN = 0;

	// ==========================================
	// Bus messages and reset values
	localparam logic [4:0] BRS_ADDR_RST = 5'h12;
	localparam logic [31:0] BRS_ZERO = 32'h0000_0000;

	// Bus-side events from the acceptor, one pulse each; ren is a level.
	typedef struct packed {
		logic       ifc;
		logic       ren;
		logic       llo;
		logic       gtl;
		logic       unt;
		logic       unl;
		logic       talk_addr;
		logic       listen_addr;
	} brs_bus_t;

	// Device-dependent command byte stream from the parser.
	typedef struct packed {
		logic       valid;
		logic       exec;
		logic       bad_cmd;
		logic       bad_opt;
	} brs_cmd_t;

	// Power-up check results, valid with done.
	typedef struct packed {
		logic       done;
		logic       ram_bad;
		logic       rom_bad;
		logic       setup_bad;
		logic       card_bad;
	} brs_post_t;

endpackage

/* rtl/brs_core.sv */
// Bus remote state, key gating and error status word with APB register access.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// ==========================================
// Notes on behaviour
// RQ1: Unknown command character sets illegal-command flag.
// RQ2: Bad option value sets illegal-option flag.
// RQ3: After either error, discard through next execute.
// RQ4: Loop fault at next inter-unit operation flags.
// RQ5: Execute while local sets not-in-remote flag.
// RQ6: Trigger between ready and matrix-ready flags.
// RQ7: Such trigger is still acted upon.
// RQ8: Trigger during change: overrun only, discarded.
// RQ9: Optional service request on any error.
// RQ10: Bad setup checksum: clear, show, flag.
// RQ11: Memory faults reported, message cleared by key.
// RQ12: Card identify checksum mismatch is reported.
// RQ13: Talk address enters talker; UNT/MLA/IFC leave.
// RQ14: Listen address enters listener; UNL/MTA/IFC leave.
// RQ15: Remote only when listen-addressed with REN.
// RQ16: In remote, only the local key works.
// RQ17: Local key cancels remote, restores display.
// RQ18: Local key ignored under lockout.
// RQ19: Operator finishes panel edits before bus programming.
// RQ20: Reset: local, idle, no lockout, flags clear.
module brs_core (
	// APB slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Bus events and command stream, same clock
	input  wire brs_pkg::brs_bus_t bus_evt,
	input  wire brs_pkg::brs_cmd_t cmd,
	input  wire brs_pkg::brs_post_t post,
	// Trigger and loop status
	input  wire logic              trig,
	input  wire logic              trig_ready,
	input  wire logic              matrix_ready,
	input  wire logic              loop_op,
	input  wire logic              loop_fault,
	// Front panel keys, asynchronous pins
	input  wire logic              key_any,
	input  wire logic              key_local,
	// Outputs
	output logic                   key_pass,
	output logic                   trig_go,
	output logic                   exec_go,
	output logic                   setup_clear,
	output logic                   display_normal,
	output logic                   talk_led,
	output logic                   listen_led,
	output logic                   remote_led,
	output logic                   err_msg,
	output logic                   srq
);
	import brs_pkg::*;

	// ==========================================
	// Key synchronisers
	logic [1:0] keya_ff, keyl_ff;
	logic       keya_d_ff, keyl_d_ff;
	wire        keya_s = keya_ff[1];
	wire        keyl_s = keyl_ff[1];
	wire        keya_rise = keya_s & ~keya_d_ff;
	wire        keyl_rise = keyl_s & ~keyl_d_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keya_ff <= 2'h0;
			keyl_ff <= 2'h0;
			keya_d_ff <= 1'b0;
			keyl_d_ff <= 1'b0;
		end else begin
			keya_ff <= {keya_ff[0], key_any};
			keyl_ff <= {keyl_ff[0], key_local};
			keya_d_ff <= keya_s;
			keyl_d_ff <= keyl_s;
		end
	end

	// ==========================================
	// Talker, listener, remote and lockout
	logic talk_ff, listen_ff, remote_ff, llo_ff;
	wire  local_ok = keyl_rise & ~llo_ff;                       // RQ18
	wire  nxt_talk = bus_evt.ifc | bus_evt.unt | bus_evt.listen_addr ? 1'b0 : // RQ13
	                 bus_evt.talk_addr ? 1'b1 : talk_ff;
	wire  nxt_listen = bus_evt.ifc | bus_evt.unl | bus_evt.talk_addr ? 1'b0 : // RQ14
	                   bus_evt.listen_addr ? 1'b1 : listen_ff;
	// REN alone never sets remote; dropping REN clears remote and lockout.
	// REN comes from logic on this clock, so it is used unregistered: a listen
	// address in the same cycle as REN rising must already take the unit remote.
	wire  nxt_remote = ~bus_evt.ren | bus_evt.ifc | bus_evt.gtl | local_ok ? 1'b0 : // RQ17
	                   bus_evt.listen_addr ? 1'b1 : remote_ff;                  // RQ15
	wire  nxt_llo = ~bus_evt.ren ? 1'b0 : (bus_evt.llo ? 1'b1 : llo_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin                                         // RQ20
			talk_ff <= 1'b0;
			listen_ff <= 1'b0;
			remote_ff <= 1'b0;
			llo_ff <= 1'b0;
		end else begin
			talk_ff <= nxt_talk;
			listen_ff <= nxt_listen;
			remote_ff <= nxt_remote;
			llo_ff <= nxt_llo;
		end
	end

	// ==========================================
	// Command discard and execute
	logic discard_ff;
	wire  cmd_bad = cmd.valid & (cmd.bad_cmd | cmd.bad_opt);
	wire  cmd_exec = cmd.valid & cmd.exec;
	// The discard window closes on the execute that ends the string.
	wire  nxt_discard = cmd_bad ? ~cmd_exec : (cmd_exec ? 1'b0 : discard_ff); // RQ3
	wire  nxt_exec_go = cmd_exec & ~cmd_bad & ~discard_ff & remote_ff;

	// ==========================================
	// Trigger tracking
	logic busy_ff, settle_ff;
	wire  trig_in_busy = trig & busy_ff;                         // RQ8
	wire  trig_in_settle = trig & settle_ff;                     // RQ6
	wire  trig_accept = trig & ~busy_ff;                         // RQ7
	wire  nxt_busy = trig_accept ? 1'b1 : (trig_ready ? 1'b0 : busy_ff);
	wire  nxt_settle = trig_accept ? 1'b0 :
	                   (busy_ff & trig_ready) ? 1'b1 :
	                   (matrix_ready ? 1'b0 : settle_ff);

	// ==========================================
	// Error status word
	logic [BRS_NERR-1:0] err_ff;
	logic                msg_ff, srqen_ff, post_seen_ff;
	logic [BRS_NERR-1:0] err_set;
	wire  post_now = post.done & ~post_seen_ff;
	wire  rd_errword = psel & penable & pready & ~pwrite & (paddr == BRS_ADDR_ERRWORD);

	always_comb begin
		err_set = '0;
		err_set[BRS_E_CMD] = cmd.valid & cmd.bad_cmd;            // RQ1
		err_set[BRS_E_OPT] = cmd.valid & cmd.bad_opt & ~cmd.bad_cmd; // RQ2
		err_set[BRS_E_LOOP] = loop_op & loop_fault;              // RQ4
		err_set[BRS_E_NREM] = cmd_exec & ~remote_ff;             // RQ5
		err_set[BRS_E_NSET] = trig_in_settle;                    // RQ6
		err_set[BRS_E_OVR] = trig_in_busy;                       // RQ8
		err_set[BRS_E_SETUP] = post_now & post.setup_bad;        // RQ10
		err_set[BRS_E_RAM] = post_now & post.ram_bad;            // RQ11
		err_set[BRS_E_ROM] = post_now & post.rom_bad;            // RQ11
		err_set[BRS_E_CARD] = post_now & post.card_bad;          // RQ12
	end

	// Reading the word clears only the flags it returned, at the edge that ends the
	// transfer; a flag raised after the data was captured survives to the next read.
	wire [BRS_NERR-1:0] nxt_err = (err_ff & ~(rd_errword ? prdata[BRS_NERR-1:0] : '0)) |
	                              err_set;
	wire post_msg = post_now & (post.setup_bad | post.ram_bad | post.rom_bad | post.card_bad);
	wire nxt_msg = post_msg ? 1'b1 : (keya_rise | keyl_rise ? 1'b0 : msg_ff); // RQ11

	// ==========================================
	// APB access
	// Writes land only at the edge where the master sees pready high.
	wire wr_en = psel & penable & pready & pwrite;
	wire rd_en = psel & penable & ~pready & ~pwrite;
	wire hit = (paddr == BRS_ADDR_STATUS) | (paddr == BRS_ADDR_ERRWORD) |
	           (paddr == BRS_ADDR_CTRL) | (paddr == BRS_ADDR_ADDR);
	wire [31:0] stat_word = {24'h000000, msg_ff, settle_ff, busy_ff, discard_ff,
	                         llo_ff, remote_ff, listen_ff, talk_ff};
	wire [31:0] rd_mux = (paddr == BRS_ADDR_STATUS) ? stat_word :
	                     (paddr == BRS_ADDR_ERRWORD) ? {22'h000000, err_ff} :
	                     (paddr == BRS_ADDR_CTRL) ? {31'h00000000, srqen_ff} : BRS_ZERO;
	wire nxt_srqen = (wr_en & (paddr == BRS_ADDR_CTRL)) ? pwdata[BRS_C_SRQEN] : srqen_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discard_ff <= 1'b0;
			busy_ff <= 1'b0;
			settle_ff <= 1'b0;
			err_ff <= '0;
			msg_ff <= 1'b0;
			srqen_ff <= 1'b0;
			post_seen_ff <= 1'b0;
			prdata <= BRS_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
			key_pass <= 1'b0;
			trig_go <= 1'b0;
			exec_go <= 1'b0;
			setup_clear <= 1'b0;
			display_normal <= 1'b0;
			talk_led <= 1'b0;
			listen_led <= 1'b0;
			remote_led <= 1'b0;
			err_msg <= 1'b0;
			srq <= 1'b0;
		end else begin
			discard_ff <= nxt_discard;
			busy_ff <= nxt_busy;
			settle_ff <= nxt_settle;
			err_ff <= nxt_err;
			msg_ff <= nxt_msg;
			srqen_ff <= nxt_srqen;
			post_seen_ff <= post_seen_ff | post.done;
			prdata <= rd_en ? rd_mux : BRS_ZERO;
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			key_pass <= keya_s & ~nxt_remote;                        // RQ16
			trig_go <= trig_accept;                                  // RQ7
			exec_go <= nxt_exec_go;                                  // RQ3
			setup_clear <= post_now & post.setup_bad;                // RQ10
			display_normal <= local_ok & remote_ff;                  // RQ17
			talk_led <= nxt_talk;                                    // RQ13
			listen_led <= nxt_listen;                                // RQ14
			remote_led <= nxt_remote;                                // RQ15
			err_msg <= nxt_msg;                                      // RQ10
			srq <= srqen_ff & (|nxt_err);                            // RQ9
		end
	end
endmodule

/* verification/brs_ctl.sv */
// Behavioural bus controller model that drives the bus event pulses, dropping all but IFC while key_any is high.
`timescale 1ns/1ps
module brs_ctl (
	// Clock and requests from the bench
	input  wire logic        pclk,
	input  wire logic [7:0]  req,
	input  wire logic        ren,
	input  wire logic        key_any,
	// Events to the block
	output brs_pkg::brs_bus_t bus_evt = '0
);
	import brs_pkg::*;
	// ==========================================
	// Bus pulses other than IFC are dropped while key_any is high, so a panel edit is never overrun.
	always @(posedge pclk) begin
		bus_evt <= brs_bus_t'({req[7], ren, req[5:0] & {6{!key_any}}});
	end
endmodule

/* verification/brs_core_chk.sv */
// Checker for the APB answer, bus addressing states and key gating.
`timescale 1ns/1ps
module brs_chk (
	// Clock, reset and APB
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	// Bus, commands and outputs
	input wire brs_pkg::brs_bus_t bus_evt,
	input wire brs_pkg::brs_cmd_t cmd,
	input wire logic              talk_led,
	input wire logic              listen_led,
	input wire logic              remote_led,
	input wire logic              key_pass,
	input wire logic              exec_go
);
	import brs_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Properties
	sequence listen_ren;
		bus_evt.ren && bus_evt.listen_addr;
	endsequence
	apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
	talk_on_a: assert property (bus_evt.talk_addr |=> talk_led) else $error("talk not set");
	talk_off_a: assert property (
		bus_evt.unt || bus_evt.listen_addr || bus_evt.ifc |=> !talk_led) else $error("talk held");
	listen_on_a: assert property (bus_evt.listen_addr |=> listen_led) else $error("no listen");
	listen_off_a: assert property (
		bus_evt.unl || bus_evt.talk_addr || bus_evt.ifc |=> !listen_led) else $error("listen held");
	remote_on_a: assert property (listen_ren |=> remote_led) else $error("remote not set");
	ren_alone_a: assert property (
		!remote_led && !bus_evt.listen_addr |=> !remote_led) else $error("remote without listen");
	remote_keys_a: assert property (
		remote_led && $past(remote_led) |-> !key_pass) else $error("key passed in remote");
	local_exec_a: assert property (
		cmd.valid && cmd.exec && !remote_led |=> !exec_go) else $error("execute while local");
endmodule
bind brs_core brs_chk chk (.pclk, .presetn, .psel, .penable, .pready, .bus_evt, .cmd,
	.talk_led, .listen_led, .remote_led, .key_pass, .exec_go);

/* verification/brs_core_tb.sv */
// Self-checking bench for the bus remote state and error flag block.
`timescale 1ns/1ps
module brs_core_tb;
	import brs_pkg::*;
	// ==========================================
	// Signals and step table
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        trig = 1'b0, trig_ready = 1'b0, matrix_ready = 1'b0, ren = 1'b0, dn, kp;
	logic        loop_op = 1'b0, loop_fault = 1'b0, key_any = 1'b0, key_local = 1'b0;
	logic        pready, pslverr, key_pass, trig_go, exec_go, setup_clear, display_normal;
	logic        talk_led, listen_led, remote_led, err_msg, srq;
	logic [7:0]  req = 8'h00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	// Each step: ren, ready, settled, trigger, command, bus pulses; then expected outputs.
	logic [23:0] st [27] = '{24'h000210, 24'h000108, 24'h000210, 24'h000800, 24'h000108,
		24'h000400, 24'h000210, 24'h008000, 24'h000108, 24'h008000, 24'h800000, 24'h80010C,
		24'h8C000E, 24'h8A000C, 24'h8C000C, 24'h8C000E, 24'h89000C, 24'h8C000C, 24'h80010C,
		24'h80200C, 24'h000008, 24'h0C0008, 24'h100009, 24'h100008, 24'h400008, 24'h100009,
		24'h200008};
	brs_bus_t    bus_evt;
	brs_cmd_t    cmd = '0;
	brs_post_t   post = '0;
	int          bad_count = 0, comparisons = 0;
	brs_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .bus_evt, .cmd, .post, .trig, .trig_ready, .matrix_ready, .loop_op,
		.loop_fault, .key_any, .key_local, .key_pass, .trig_go, .exec_go, .setup_clear,
		.display_normal, .talk_led, .listen_led, .remote_led, .err_msg, .srq);
	brs_ctl ctl (.pclk, .req, .ren, .key_any, .bus_evt);
	always #12.5 pclk = ~pclk;
	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("BAD at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		chk({pslverr, prdata}, e);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			req <= st[i][15:8];
			ren <= st[i][23];
			@(posedge pclk) req <= 8'h00;
			{trig_ready, matrix_ready, trig, cmd} <= st[i][22:16];
			@(posedge pclk) {trig_ready, matrix_ready, trig, cmd} <= 7'h00;
			@(posedge pclk);
			chk({talk_led, listen_led, remote_led, exec_go, trig_go}, st[i][4:0]);
		end
		$display("steps %0d to %0d done", lo, hi);
	endtask
	task automatic key(input logic l);
		dn = 1'b0;
		key_local <= l;
		key_any <= !l;
		repeat (6) begin
			@(posedge pclk);
			dn = dn | (display_normal === 1'b1);
		end
		kp = key_pass;
		key_local <= 1'b0;
		key_any <= 1'b0;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, BRS_ADDR_STATUS, 32'h0, 33'h0);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h0);
		post <= brs_post_t'(5'h1F);
		repeat (2) @(posedge pclk);
		chk({setup_clear, err_msg}, 33'h3);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h3C0);
		key(1'b0);
		chk({kp, err_msg}, 33'h2);
		run(0, 17);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h3);
		key(1'b0);
		chk(kp, 33'h0);
		apb(1'b1, BRS_ADDR_CTRL, 32'h1, 33'h0);
		loop_fault <= 1'b1;
		loop_op <= 1'b1;
		@(posedge pclk) loop_op <= 1'b0;
		loop_fault <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(srq, 33'h1);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h4);
		key(1'b1);
		chk({remote_led, dn}, 33'h1);
		run(18, 19);
		key(1'b1);
		chk(remote_led, 33'h1);
		run(20, 21);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h8);
		run(22, 26);
		apb(1'b0, BRS_ADDR_ERRWORD, 32'h0, 33'h30);
		apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
		final_report;
	end
	// The tests need under two hundred cycles, so 3000 cycles means a hang.
	initial begin
		#75000;
		bad_count++;
		final_report;
	end
endmodule
